// [hw/tmr16_pkg.sv]
// Function
// - count pair upward, wrap all-ones to zero, latch overflow flag on wrap
// - interrupt output only when enable bit set; flag latches regardless
// - wide access bit buffers the high byte so two byte accesses act as one 16-bit access, else bytes are separate
// - capture timer select: 1x both units, 01 unit two only, 00 none
// - prescale select 11=1:8, 10=1:4, 01=1:2, 00=1:1 before increment
// - external clocking: bypass bit 1 skips the extra tick stage after the synchroniser, ignored when internal
// - source 0 counts every cycle; 1 counts rising edges after first fall
// - counts only while run bit is set; when clear, only writes and the trigger reset change it
// - three modes: timer, synchronous counter, asynchronous counter
// - aux oscillator enabled forces both oscillator pins to inputs
// - aux oscillator switched on by enable bit in sibling control
// - compare unit in mode 1011 resets counter on its trigger when unit one is assigned to this timer
// - trigger reset never sets the overflow flag
// - software write in same cycle as trigger wins over the reset
// - compare value acts as period, count restarts from zero two cycles after match
// - compare unit matches compare value against its assigned timer count
package tmr16_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_COUNT_LO  = 8'h04;
    localparam logic [7:0] OFS_COUNT_HI  = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h10;
    localparam logic [7:0] OFS_SIB_CTRL  = 8'h14;
    localparam logic [7:0] OFS_CMP_MODE  = 8'h18;
    localparam logic [7:0] OFS_CMP_VALUE = 8'h1C;

    // ------------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------------
    localparam int CTL_RUN      = 0;
    localparam int CTL_CS       = 1;
    localparam int CTL_SYNC_BYP = 2;
    localparam int CTL_SEL_LO   = 3;
    localparam int CTL_PS_LO    = 4;
    localparam int CTL_PS_HI    = 5;
    localparam int CTL_SEL_HI   = 6;
    localparam int CTL_WIDE     = 7;
    localparam int SIB_OSC_EN   = 3;

    // ------------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  CONTROL_RST   = 8'h00;
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [7:0]  SIB_CTRL_RST  = 8'h00;
    localparam logic [3:0]  CMP_MODE_RST  = 4'h0;
    localparam logic [15:0] CMP_VALUE_RST = 16'h0000;
    localparam logic [3:0]  MODE_SPECIAL  = 4'hB;

    typedef enum logic [1:0] {
        TMR16_PS_1,
        TMR16_PS_2,
        TMR16_PS_4,
        TMR16_PS_8
    } tmr16_ps_t;

endpackage

// [hw/tmr16_sync.sv]
`timescale 1ns/10ps
module tmr16_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      rise,
    output logic      fall
);

    logic stage1_r;
    logic stage2_r;
    logic stage3_r;
    logic stage1_nxt;
    logic stage2_nxt;
    logic stage3_nxt;

    always_comb begin
        stage1_nxt = din;
        stage2_nxt = stage1_r;
        stage3_nxt = stage2_r;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
            stage3_r <= 1'b0;
        end else begin
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
            stage3_r <= stage3_nxt;
        end
    end

    // edges seen only after the second stage, never the first
    assign rise = stage2_r & ~stage3_r;
    assign fall = ~stage2_r & stage3_r;

endmodule

// [hw/tmr16_core.sv]
`timescale 1ns/10ps
module tmr16_core (
    input  wire logic        CLOCK,
    input  wire logic        RST_B,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        EXT_COUNT_IN,
    input  wire logic        AUX_OSC_IN,
    input  wire logic [1:0]  PORT_DIR_OUT,
    input  wire logic [15:0] SIB_COUNT,
    output logic             IRQ,
    output logic             CCP1_USES_THIS,
    output logic             CCP2_USES_THIS,
    output logic             AUX_OSC_EN,
    output logic [1:0]       OSC_PIN_OE,
    output logic             SPECIAL_TRIG
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] presc_mask(input logic [1:0] sel);
        unique case (tmr16_pkg::tmr16_ps_t'(sel))
            tmr16_pkg::TMR16_PS_1: presc_mask = 3'h0;
            tmr16_pkg::TMR16_PS_2: presc_mask = 3'h1;
            tmr16_pkg::TMR16_PS_4: presc_mask = 3'h3;
            tmr16_pkg::TMR16_PS_8: presc_mask = 3'h7;
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]  ctl_r,       ctl_nxt;
    logic [15:0] count_r,     count_nxt;
    logic [7:0]  hi_buf_r,    hi_buf_nxt;
    logic        ovf_r,       ovf_nxt;
    logic        ie_r,        ie_nxt;
    logic [7:0]  sib_r,       sib_nxt;
    logic [3:0]  cmp_mode_r,  cmp_mode_nxt;
    logic [15:0] cmp_val_r,   cmp_val_nxt;
    logic [2:0]  pre_r,       pre_nxt;
    logic        armed_r,     armed_nxt;
    logic        tick_q_r,    tick_q_nxt;
    logic [31:0] prdata_r,    prdata_nxt;
    logic        pready_r,    pready_nxt;
    logic        pslverr_r,   pslverr_nxt;
    logic        irq_r,       irq_nxt;
    logic [1:0]  pin_oe_r,    pin_oe_nxt;
    logic        trig_r,      trig_nxt;
    logic        ccp2_r,      ccp2_nxt;

    logic        ext_src;
    logic        ext_rise;
    logic        ext_fall;
    logic        run;
    logic        ext_mode;
    logic        wide;
    logic        ext_tick;
    logic        src_tick;
    logic        inc;
    logic        acc_first;
    logic        acc_done;
    logic        wr_done;
    logic        mapped;
    logic        wr_lo;
    logic        wr_hi;
    logic        sw_count_wr;
    logic        unit1_this;
    logic        match;
    logic [15:0] unit1_count;

    assign run      = ctl_r[tmr16_pkg::CTL_RUN];
    assign ext_mode = ctl_r[tmr16_pkg::CTL_CS];
    assign wide     = ctl_r[tmr16_pkg::CTL_WIDE];

    // ------------------------------------------------------------------
    // external edge input
    // ------------------------------------------------------------------
    // aux oscillator select
    assign ext_src = sib_r[tmr16_pkg::SIB_OSC_EN] ? AUX_OSC_IN : EXT_COUNT_IN;

    tmr16_sync u_sync (
        .clk   (CLOCK),
        .rst_b (RST_B),
        .din   (ext_src),
        .rise  (ext_rise),
        .fall  (ext_fall)
    );

    always_comb begin
        if (!run || !ext_mode) begin
            armed_nxt = 1'b0;
        end else if (ext_fall) begin
            armed_nxt = 1'b1;
        end else begin
            armed_nxt = armed_r;
        end
    end

    assign ext_tick   = armed_r & ext_rise;
    assign tick_q_nxt = ext_tick;

    // mode and sync choice; synchronous mode adds one stage
    always_comb begin
        if (!ext_mode) begin
            src_tick = 1'b1;
        end else if (ctl_r[tmr16_pkg::CTL_SYNC_BYP]) begin
            src_tick = ext_tick;
        end else begin
            src_tick = tick_q_r;
        end
    end

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // one wait state: data is prepared, then PREADY rises
    assign acc_first = PSEL & PENABLE & ~pready_r;
    assign acc_done  = PSEL & PENABLE & pready_r;
    assign wr_done   = acc_done & PWRITE & ~pslverr_r;

    always_comb begin
        mapped = hit(PADDR, tmr16_pkg::OFS_CONTROL)
               | hit(PADDR, tmr16_pkg::OFS_COUNT_LO)
               | hit(PADDR, tmr16_pkg::OFS_COUNT_HI)
               | hit(PADDR, tmr16_pkg::OFS_STATUS)
               | hit(PADDR, tmr16_pkg::OFS_IRQ_EN)
               | hit(PADDR, tmr16_pkg::OFS_SIB_CTRL)
               | hit(PADDR, tmr16_pkg::OFS_CMP_MODE)
               | hit(PADDR, tmr16_pkg::OFS_CMP_VALUE);
    end

    assign wr_lo       = wr_done & hit(PADDR, tmr16_pkg::OFS_COUNT_LO);
    assign wr_hi       = wr_done & hit(PADDR, tmr16_pkg::OFS_COUNT_HI);
    assign sw_count_wr = wr_lo | (wr_hi & ~wide);

    always_comb begin
        pready_nxt  = acc_first;
        pslverr_nxt = acc_first ? ~mapped : 1'b0;
        prdata_nxt  = prdata_r;
        hi_buf_nxt  = hi_buf_r;
        if (acc_first && !PWRITE) begin
            prdata_nxt = 32'h0000_0000;
            if (hit(PADDR, tmr16_pkg::OFS_CONTROL)) begin
                prdata_nxt[7:0] = ctl_r;
            end
            if (hit(PADDR, tmr16_pkg::OFS_COUNT_LO)) begin
                prdata_nxt[7:0] = count_r[7:0];
                if (wide) begin
                    hi_buf_nxt = count_r[15:8];
                end
            end
            if (hit(PADDR, tmr16_pkg::OFS_COUNT_HI)) begin
                prdata_nxt[7:0] = wide ? hi_buf_r : count_r[15:8];
            end
            if (hit(PADDR, tmr16_pkg::OFS_STATUS)) begin
                prdata_nxt[0] = ovf_r;
            end
            if (hit(PADDR, tmr16_pkg::OFS_IRQ_EN)) begin
                prdata_nxt[0] = ie_r;
            end
            if (hit(PADDR, tmr16_pkg::OFS_SIB_CTRL)) begin
                prdata_nxt[7:0] = sib_r;
            end
            if (hit(PADDR, tmr16_pkg::OFS_CMP_MODE)) begin
                prdata_nxt[3:0] = cmp_mode_r;
            end
            if (hit(PADDR, tmr16_pkg::OFS_CMP_VALUE)) begin
                prdata_nxt[15:0] = cmp_val_r;
            end
        end
        if (wr_hi && wide) begin
            hi_buf_nxt = PWDATA[7:0];
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_comb begin
        ctl_nxt      = ctl_r;
        ie_nxt       = ie_r;
        sib_nxt      = sib_r;
        cmp_mode_nxt = cmp_mode_r;
        cmp_val_nxt  = cmp_val_r;
        if (wr_done && hit(PADDR, tmr16_pkg::OFS_CONTROL)) begin
            ctl_nxt = PWDATA[7:0];
        end
        if (wr_done && hit(PADDR, tmr16_pkg::OFS_IRQ_EN)) begin
            ie_nxt = PWDATA[0];
        end
        if (wr_done && hit(PADDR, tmr16_pkg::OFS_SIB_CTRL)) begin
            sib_nxt = PWDATA[7:0];
        end
        if (wr_done && hit(PADDR, tmr16_pkg::OFS_CMP_MODE)) begin
            cmp_mode_nxt = PWDATA[3:0];
        end
        if (wr_done && hit(PADDR, tmr16_pkg::OFS_CMP_VALUE)) begin
            cmp_val_nxt = PWDATA[15:0];
        end
    end

    // ------------------------------------------------------------------
    // compare unit one and counter
    // ------------------------------------------------------------------
    // timer assignment
    assign unit1_this  = ctl_r[tmr16_pkg::CTL_SEL_HI];
    assign unit1_count = unit1_this ? count_r : SIB_COUNT;

    assign match    = (cmp_mode_r == tmr16_pkg::MODE_SPECIAL)
                    & (unit1_count == cmp_val_r);
    assign trig_nxt = match;

    // prescaler, cleared by low-byte writes only
    always_comb begin
        pre_nxt = pre_r;
        inc     = 1'b0;
        if (wr_lo) begin
            pre_nxt = 3'h0;
        end else if (run && src_tick) begin
            if (pre_r == presc_mask(ctl_r[tmr16_pkg::CTL_PS_HI:
                                          tmr16_pkg::CTL_PS_LO])) begin
                pre_nxt = 3'h0;
                inc     = 1'b1;
            end else begin
                pre_nxt = pre_r + 3'h1;
            end
        end
    end

    always_comb begin
        count_nxt = count_r;
        ovf_nxt   = ovf_r;
        // software clears the flag by writing one
        if (wr_done && hit(PADDR, tmr16_pkg::OFS_STATUS) && PWDATA[0]) begin
            ovf_nxt = 1'b0;
        end
        if (sw_count_wr) begin
            if (wr_lo) begin
                count_nxt = wide ? {hi_buf_r, PWDATA[7:0]}
                                 : {count_r[15:8], PWDATA[7:0]};
            end else begin
                count_nxt = {PWDATA[7:0], count_r[7:0]};
            end
        end else if (trig_r && unit1_this) begin
            count_nxt = tmr16_pkg::COUNT_RST;
        end else if (inc) begin
            // wrap and latch; set wins over clear
            count_nxt = count_r + 16'h0001;
            if (count_r == tmr16_pkg::COUNT_MAX) begin
                ovf_nxt = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------
    // gated interrupt
    assign irq_nxt = ovf_r & ie_r;

    assign pin_oe_nxt = sib_r[tmr16_pkg::SIB_OSC_EN] ? 2'h0 : PORT_DIR_OUT;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ctl_r      <= tmr16_pkg::CONTROL_RST;
            count_r    <= tmr16_pkg::COUNT_RST;
            hi_buf_r   <= 8'h00;
            ovf_r      <= 1'b0;
            ie_r       <= 1'b0;
            sib_r      <= tmr16_pkg::SIB_CTRL_RST;
            cmp_mode_r <= tmr16_pkg::CMP_MODE_RST;
            cmp_val_r  <= tmr16_pkg::CMP_VALUE_RST;
            pre_r      <= 3'h0;
            armed_r    <= 1'b0;
            tick_q_r   <= 1'b0;
            prdata_r   <= 32'h0000_0000;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            irq_r      <= 1'b0;
            pin_oe_r   <= 2'h0;
            trig_r     <= 1'b0;
            ccp2_r     <= 1'b0;
        end else begin
            ctl_r      <= ctl_nxt;
            count_r    <= count_nxt;
            hi_buf_r   <= hi_buf_nxt;
            ovf_r      <= ovf_nxt;
            ie_r       <= ie_nxt;
            sib_r      <= sib_nxt;
            cmp_mode_r <= cmp_mode_nxt;
            cmp_val_r  <= cmp_val_nxt;
            pre_r      <= pre_nxt;
            armed_r    <= armed_nxt;
            tick_q_r   <= tick_q_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            irq_r      <= irq_nxt;
            pin_oe_r   <= pin_oe_nxt;
            trig_r     <= trig_nxt;
            ccp2_r     <= ccp2_nxt;
        end
    end

    assign PRDATA         = prdata_r;
    assign PREADY         = pready_r;
    assign PSLVERR        = pslverr_r;
    assign IRQ            = irq_r;
    // unit two uses this timer for 1x and 01
    assign CCP1_USES_THIS = ctl_r[tmr16_pkg::CTL_SEL_HI];
    assign ccp2_nxt       = ctl_nxt[tmr16_pkg::CTL_SEL_HI]
                          | ctl_nxt[tmr16_pkg::CTL_SEL_LO];
    assign CCP2_USES_THIS = ccp2_r;
    assign AUX_OSC_EN     = sib_r[tmr16_pkg::SIB_OSC_EN];
    assign OSC_PIN_OE     = pin_oe_r;
    assign SPECIAL_TRIG   = trig_r;

endmodule

// [test/tmr16_checker.sv]
`timescale 1ns/10ps
module tmr16_checker (
    input wire logic        CLOCK,
    input wire logic        RST_B,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [1:0]  PORT_DIR_OUT,
    input wire logic        IRQ,
    input wire logic        CCP1_USES_THIS,
    input wire logic        CCP2_USES_THIS,
    input wire logic        AUX_OSC_EN,
    input wire logic [1:0]  OSC_PIN_OE
);
    // ------------------------------------------------------------------
    // shadow of the software-written control bits
    // ------------------------------------------------------------------
    logic [7:0] ctl_r, ctl_nxt, sib_r, sib_nxt;
    logic       ien_r, ien_nxt, wr_ok;
    logic [1:0] live_r, live_nxt;

    assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;

    always_comb begin
        ctl_nxt = ctl_r;
        sib_nxt = sib_r;
        ien_nxt = ien_r;
        live_nxt = live_r + {1'b0, live_r != 2'h3};
        if (wr_ok && PADDR == tmr16_pkg::OFS_CONTROL)
            ctl_nxt = PWDATA[7:0];
        if (wr_ok && PADDR == tmr16_pkg::OFS_SIB_CTRL)
            sib_nxt = PWDATA[7:0];
        if (wr_ok && PADDR == tmr16_pkg::OFS_IRQ_EN)
            ien_nxt = PWDATA[0];
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ctl_r <= 8'h00;
            sib_r <= 8'h00;
            ien_r <= 1'b0;
            live_r <= 2'h0;
        end else begin
            ctl_r <= ctl_nxt;
            sib_r <= sib_nxt;
            ien_r <= ien_nxt;
            live_r <= live_nxt;
        end
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    chk_ready_lat: assert property (
        PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY)
        else $error("ready not in second access cycle");
    chk_ready_pulse: assert property (
        PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    chk_bad_addr: assert property (
        PREADY |-> PSLVERR == (PADDR > tmr16_pkg::OFS_CMP_VALUE
            || PADDR[1:0] != 2'h0) && (PWRITE || !PSLVERR || PRDATA == 0))
        else $error("error response mismatch");
    chk_rdata_hold: assert property (
        !(PSEL && PENABLE && !PWRITE) |=> $stable(PRDATA))
        else $error("read data moved without a read");
    chk_sel_map: assert property (
        $stable(ctl_r) |-> CCP1_USES_THIS == ctl_r[6]
            && CCP2_USES_THIS == (ctl_r[6] | ctl_r[3]))
        else $error("capture timer select mismatch");
    chk_aux_follow: assert property (
        $stable(sib_r) |-> AUX_OSC_EN == sib_r[3])
        else $error("aux oscillator enable mismatch");
    chk_osc_inputs: assert property (
        live_r == 2'h3 |-> OSC_PIN_OE
            == ($past(AUX_OSC_EN) ? 2'h0 : $past(PORT_DIR_OUT)))
        else $error("oscillator pin enable mismatch");
    chk_irq_mask: assert property (
        $stable(ien_r) && !ien_r |-> !IRQ)
        else $error("interrupt while disabled");

    cover property (PREADY && PSLVERR);
    cover property (IRQ);
    cover property (AUX_OSC_EN && OSC_PIN_OE == 2'h0);
endmodule

// [test/tmr16_ext_src.sv]
`timescale 1ns/10ps
module tmr16_ext_src #(
    parameter realtime HALF = 44.0
) (
    input  wire logic en,
    output logic      pin,
    output int        n_rise
);
    initial begin
        pin = 1'b1;
        n_rise = 0;
    end

    // fall before rise
    // idles high between bursts, so every burst opens with a fall
    always begin
        wait (en === 1'b1);
        #(HALF) pin = 1'b0;
        #(HALF) pin = 1'b1;
        n_rise = n_rise + 1;
    end
endmodule

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    localparam logic [7:0] CT = tmr16_pkg::OFS_CONTROL;
    localparam logic [7:0] LO = tmr16_pkg::OFS_COUNT_LO;
    localparam logic [7:0] HI = tmr16_pkg::OFS_COUNT_HI;
    localparam logic [7:0] ST = tmr16_pkg::OFS_STATUS;
    localparam logic [7:0] IE = tmr16_pkg::OFS_IRQ_EN;
    localparam logic [7:0] SB = tmr16_pkg::OFS_SIB_CTRL;
    localparam logic [7:0] CM = tmr16_pkg::OFS_CMP_MODE;
    localparam logic [7:0] CV = tmr16_pkg::OFS_CMP_VALUE;

    logic        clk = 1'b0, rst_b = 1'b0;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, ext_pin, osc_pin, irq, u1, u2;
    logic        aux_en, trig, en_pin = 1'b0, en_osc = 1'b0;
    logic [1:0]  dir_out = 2'h0, osc_oe;
    logic [15:0] sib_cnt = 16'h0000;
    int          num_errors = 0, n_tests = 0, n_pin, n_osc;

    always #4 clk = ~clk;

    tmr16_core DUT (
        .CLOCK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXT_COUNT_IN(ext_pin),
        .AUX_OSC_IN(osc_pin), .PORT_DIR_OUT(dir_out), .SIB_COUNT(sib_cnt),
        .IRQ(irq), .CCP1_USES_THIS(u1), .CCP2_USES_THIS(u2),
        .AUX_OSC_EN(aux_en), .OSC_PIN_OE(osc_oe), .SPECIAL_TRIG(trig));
    // slow partner stands for the low-power oscillator
    // odd half periods keep pin edges off the sampling clock edge
    tmr16_ext_src #(.HALF(44.3)) u_pin (
        .en(en_pin), .pin(ext_pin), .n_rise(n_pin));
    tmr16_ext_src #(.HALF(150.3)) u_osc (
        .en(en_osc), .pin(osc_pin), .n_rise(n_osc));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            num_errors++;
            finish_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask

    // counter sees k idle edges plus the four edges of the stop write
    task automatic run_for(input logic [7:0] c, input int k);
        wr(CT, {24'h0, c});
        repeat (k) @(posedge clk);
        wr(CT, {24'h0, c & 8'hFE});
    endtask

    task automatic wait_lvl(input logic v, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (trig !== v && k < 200);
        if (trig !== v) begin
            num_errors++;
            finish_test();
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_prescale();
        for (int p = 0; p < 5; p++) begin
            wr(HI, 32'h0);
            wr(LO, 32'h0);
            run_for(p == 4 ? 8'h05 : {2'h0, p[1:0], 4'h1}, 60);
            rd(LO, p == 4 ? 32'h40 : 32'h40 >> p);
            repeat (20) @(posedge clk);
            rd(LO, p == 4 ? 32'h40 : 32'h40 >> p);
        end
        $display("test prescale done");
    endtask

    task automatic t_wrap();
        wr(IE, 32'h0);
        wr(HI, 32'hFF);
        wr(LO, 32'hFE);
        run_for(8'h01, 6);
        rd(LO, 32'h08);
        rd(HI, 32'h00);
        rd(ST, 32'h01);
        chk({31'h0, irq}, 32'h0);
        wr(IE, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h1);
        wr(ST, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        $display("test wrap done");
    endtask

    task automatic t_wide();
        wr(CT, 32'h80);
        wr(HI, 32'h12);
        wr(LO, 32'h34);
        rd(LO, 32'h34);
        rd(HI, 32'h12);
        wr(HI, 32'h56);
        wr(CT, 32'h00);
        rd(HI, 32'h12);
        $display("test wide done");
    endtask

    task automatic t_sel_aux();
        logic [7:0] c [4] = '{8'h00, 8'h08, 8'h40, 8'h48};
        logic [1:0] x [4] = '{2'h0, 2'h2, 2'h3, 2'h3};
        for (int i = 0; i < 4; i++) begin
            wr(CT, {24'h0, c[i]});
            @(posedge clk);
            #1;
            chk({30'h0, u2, u1}, {30'h0, x[i]});
        end
        wr(SB, 32'h08);
        dir_out <= 2'h3;
        rd(SB, 32'h08);
        #1;
        chk({29'h0, aux_en, osc_oe}, 32'h4);
        wr(SB, 32'h00);
        repeat (2) @(posedge clk);
        #1;
        chk({29'h0, aux_en, osc_oe}, 32'h3);
        $display("test select done");
    endtask

    task automatic t_ext(input logic [7:0] c, input logic aux);
        int n0;
        wr(SB, {28'h0, aux, 3'h0});
        wr(LO, 32'h0);
        wr(CT, {24'h0, c});
        n0 = aux ? n_osc : n_pin;
        en_osc <= aux;
        en_pin <= !aux;
        repeat (200) @(posedge clk);
        en_osc <= 1'b0;
        en_pin <= 1'b0;
        repeat (60) @(posedge clk);
        wr(CT, 32'h0);
        rd(LO, 32'((aux ? n_osc : n_pin) - n0));
        $display("test external %h done", c);
    endtask

    task automatic t_trig();
        int k;
        logic [31:0] q;
        logic        e;
        wr(ST, 32'h1);
        wr(CM, {28'h0, tmr16_pkg::MODE_SPECIAL});
        wr(CV, 32'h10);
        wr(HI, 32'h0);
        wr(LO, 32'h0);
        wr(CT, 32'h41);
        wait_lvl(1'b1, k);
        wait_lvl(1'b0, k);
        wait_lvl(1'b1, k);
        chk(32'(k + 1), 32'h12);
        wr(CT, 32'h00);
        rd(ST, 32'h0);
        sib_cnt <= 16'h0010;
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, trig}, 32'h1);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        $display("test trigger done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(CT, 32'h0);
        rd(ST, 32'h0);
        t_prescale();
        t_wrap();
        t_wide();
        t_sel_aux();
        t_ext(8'h03, 1'b0);
        t_ext(8'h07, 1'b0);
        t_ext(8'h03, 1'b1);
        t_trig();
        finish_test();
    end
endmodule

bind tmr16_core tmr16_checker u_chk (
    .CLOCK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .PORT_DIR_OUT, .IRQ, .CCP1_USES_THIS,
    .CCP2_USES_THIS, .AUX_OSC_EN, .OSC_PIN_OE);
